// [rtl/fcs_flash_host.sv]
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module fcs_flash_host
  import fcs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins
  output logic [22:0] flAddr,
  output logic [15:0] flDqOut,
  input wire logic [15:0] flDqIn,
  output logic flDqOe,
  output logic flCeN,
  output logic flOeN,
  output logic flWeN,
  output logic flResetN,
  output logic flAccelHigh,
  input wire logic flReadyBusy
);

  // command table for the third write cycle of an order
  function automatic logic [15:0] cmdThird(input logic [3:0] op);
    logic [15:0] d;
    d = DAT_AUTOSEL;
    case (op)
      OP_SEC_ENTER: d = DAT_SECURED;
      OP_PROGRAM: d = DAT_PROG;
      OP_BYP_ENTER: d = DAT_BYPASS;
      OP_CHIP_ERASE: d = DAT_ERASE_SETUP;
      default: d = DAT_AUTOSEL;
    endcase
    return d;
  endfunction

  function automatic logic [38:0] seqStep(input logic [3:0] op, input logic [2:0] idx,
                                          input logic [22:0] a, input logic [15:0] d);
    logic [22:0] sa;
    logic [15:0] sd;
    sa = ADR_ANY;
    sd = DAT_RESET;
    case (op)
      OP_RESET: sd = DAT_RESET;
      OP_SUSPEND: sd = DAT_SUSPEND;
      OP_RESUME: sd = DAT_RESUME;
      OP_BYP_PROG:
      begin
        sa = (idx == 3'h0) ? ADR_ANY : a;
        sd = (idx == 3'h0) ? DAT_PROG : d;
      end
      OP_BYP_EXIT: sd = (idx == 3'h0) ? DAT_AUTOSEL : DAT_ZERO;
      default:
      begin
        case (idx)
          3'h0, 3'h3:
          begin
            sa = ADR_UNLOCK1;
            sd = DAT_UNLOCK1;
          end
          3'h1, 3'h4:
          begin
            sa = ADR_UNLOCK2;
            sd = DAT_UNLOCK2;
          end
          3'h2:
          begin
            sa = ADR_UNLOCK1;
            sd = cmdThird(op);
          end
          default:
          begin
            sa = ADR_UNLOCK1;
            sd = DAT_CHIP_ERASE;
          end
        endcase
        if (idx == 3'h3 && op == OP_PROGRAM)
        begin
          sa = a;
          sd = d;
        end
        if (idx == 3'h3 && op == OP_SEC_EXIT)
        begin
          sa = ADR_ANY;
          sd = DAT_ZERO;
        end
      end
    endcase
    return {sa, sd};
  endfunction

  // number of write cycles of an order
  function automatic logic [2:0] seqLen(input logic [3:0] op);
    logic [2:0] n;
    n = 3'h3;
    case (op)
      OP_READ: n = 3'h0;
      OP_RESET, OP_SUSPEND, OP_RESUME: n = 3'h1;
      OP_BYP_PROG, OP_BYP_EXIT: n = 3'h2;
      OP_SEC_EXIT, OP_PROGRAM: n = 3'h4;
      OP_CHIP_ERASE: n = 3'h6;
      default: n = 3'h3;
    endcase
    return n;
  endfunction

  logic [3:0] opFf;
  logic [22:0] addrFf;
  logic [15:0] wdataFf;
  logic [15:0] rdataFf;
  logic exceededFf;
  logic refusedFf;
  logic autoselFf;
  logic securedFf;
  logic bypassFf;
  logic suspendFf;
  logic accelFf;
  logic hwResetFf;
  fcs_state_e state_ff;
  logic [2:0] idxFf;
  logic [2:0] cntFf;
  logic pollFf;
  logic havePrevFf;
  logic prevToggleFf;
  logic [15:0] dqS1;
  logic [15:0] dqS2;
  logic [15:0] dqS3;
  logic [2:0] rbSync;
  logic [38:0] step;
  logic wrAcc;
  logic cmdWr;
  logic bypassEff;
  logic allowed;
  logic seqDone;
  logic [3:0] newOp;

  // apb answers at the first access cycle
  assign pready = 1'b1;
  assign wrAcc = psel && penable && pwrite;
  assign cmdWr = wrAcc && paddr == REG_CMD;
  assign newOp = pwdata[3:0];
  assign bypassEff = bypassFf || accelFf;
  assign step = seqStep(opFf, idxFf, addrFf, wdataFf);
  assign seqDone = (idxFf + 3'h1) == seqLen(opFf);

  // legality of a new order against the tracked mode
  always_comb
  begin
    allowed = state_ff == ST_IDLE && !hwResetFf && newOp <= OP_RESUME;
    if (bypassEff)
      allowed = allowed && (newOp == OP_READ || newOp == OP_BYP_PROG || newOp == OP_BYP_EXIT);
    else
      allowed = allowed && newOp != OP_BYP_PROG && newOp != OP_BYP_EXIT;
    if (accelFf && newOp == OP_BYP_EXIT)
      allowed = 1'b0;
  end

  // apb read mux and unmapped answer
  always_comb
  begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    case (paddr)
      REG_CMD: prdata[3:0] = opFf;
      REG_ADDR: prdata[22:0] = addrFf;
      REG_WDATA: prdata[15:0] = wdataFf;
      REG_RDATA: prdata[15:0] = rdataFf;
      REG_STATUS: prdata[7:0] = {rbSync[2], suspendFf, bypassEff, securedFf, autoselFf,
                                 refusedFf, exceededFf, state_ff != ST_IDLE};
      REG_PINCTRL: prdata[1:0] = {hwResetFf, accelFf};
      default: pslverr = psel && penable;
    endcase
  end

  // address, data and pin control registers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addrFf <= 23'h000000;
      wdataFf <= 16'h0000;
      accelFf <= 1'b0;
      hwResetFf <= 1'b0;
    end
    else if (wrAcc && state_ff == ST_IDLE)
    begin
      if (paddr == REG_ADDR)
        addrFf <= pwdata[22:0];
      if (paddr == REG_WDATA)
        wdataFf <= pwdata[15:0];
      if (paddr == REG_PINCTRL)
      begin
        accelFf <= pwdata[PC_ACCEL];
        hwResetFf <= pwdata[PC_HWRESET];
      end
    end
  end

  // three stage pin synchronisers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dqS1 <= 16'h0000;
      dqS2 <= 16'h0000;
      dqS3 <= 16'h0000;
      rbSync <= 3'h0;
    end
    else
    begin
      dqS1 <= flDqIn;
      dqS2 <= dqS1;
      dqS3 <= dqS2;
      rbSync <= {rbSync[1:0], flReadyBusy};
    end
  end

  // sticky flags, set wins over write-one-clear
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      refusedFf <= 1'b0;
      exceededFf <= 1'b0;
    end
    else
    begin
      if (cmdWr && !allowed)
        refusedFf <= 1'b1;
      else if (wrAcc && paddr == REG_STATUS && pwdata[ST_REFUSED])
        refusedFf <= 1'b0;
      // ready pin high means the changed bit is finished data, not a stuck algorithm
      if (state_ff == ST_PCHK && havePrevFf && dqS3[POS_TOGGLE] != prevToggleFf
          && dqS3[POS_EXCEEDED] && !rbSync[2])
        exceededFf <= 1'b1;
      else if (wrAcc && paddr == REG_STATUS && pwdata[ST_EXCEEDED])
        exceededFf <= 1'b0;
    end
  end

  // mode tracking updated when an order's last write is issued
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      autoselFf <= 1'b0;
      securedFf <= 1'b0;
      bypassFf <= 1'b0;
      suspendFf <= 1'b0;
    end
    else if (hwResetFf)
    begin
      autoselFf <= 1'b0;
      securedFf <= 1'b0;
      bypassFf <= 1'b0;
      suspendFf <= 1'b0;
    end
    else if (state_ff == ST_WHIGH && cntFf == 3'h0 && seqDone)
    begin
      case (opFf)
        OP_RESET: autoselFf <= 1'b0;
        OP_AUTOSEL: autoselFf <= 1'b1;
        OP_SEC_ENTER: securedFf <= 1'b1;
        OP_SEC_EXIT: securedFf <= 1'b0;
        OP_BYP_ENTER: bypassFf <= 1'b1;
        OP_BYP_EXIT: bypassFf <= 1'b0;
        OP_SUSPEND: suspendFf <= 1'b1;
        OP_RESUME: suspendFf <= 1'b0;
        OP_CHIP_ERASE: suspendFf <= 1'b0;
        default: suspendFf <= suspendFf;
      endcase
    end
  end

  // sequencer: bus cycles and completion polling
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      opFf <= OP_READ;
      idxFf <= 3'h0;
      cntFf <= 3'h0;
      pollFf <= 1'b0;
      havePrevFf <= 1'b0;
      prevToggleFf <= 1'b0;
      rdataFf <= 16'h0000;
    end
    else if (hwResetFf)
    begin
      state_ff <= ST_IDLE;
      idxFf <= 3'h0;
      pollFf <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
          if (cmdWr && allowed)
          begin
            opFf <= newOp;
            idxFf <= 3'h0;
            havePrevFf <= 1'b0;
            pollFf <= 1'b0;
            cntFf <= 3'(ACC_CYC);
            state_ff <= (newOp == OP_READ) ? ST_RACC : ST_WSET;
          end
        ST_WSET:
        begin
          cntFf <= 3'(WP_CYC);
          state_ff <= ST_WLOW;
        end
        ST_WLOW:
          if (cntFf > 3'h1)
            cntFf <= cntFf - 3'h1;
          else
          begin
            cntFf <= 3'(WPH_CYC);
            state_ff <= ST_WHIGH;
          end
        ST_WHIGH:
          if (cntFf != 3'h0)
            cntFf <= cntFf - 3'h1;
          else if (!seqDone)
          begin
            idxFf <= idxFf + 3'h1;
            state_ff <= ST_WSET;
          end
          else if (opFf == OP_PROGRAM || opFf == OP_BYP_PROG || opFf == OP_CHIP_ERASE)
          begin
            pollFf <= 1'b1;
            cntFf <= 3'(ACC_CYC);
            state_ff <= ST_RACC;
          end
          else
            state_ff <= ST_IDLE;
        ST_RACC:
          if (cntFf > 3'h1)
            cntFf <= cntFf - 3'h1;
          else
            state_ff <= ST_RCAP;
        ST_RCAP:
          if (dqS2 == dqS3)
          begin
            // id and array data returned here
            rdataFf <= dqS3;
            state_ff <= pollFf ? ST_PCHK : ST_IDLE;
          end
        ST_PCHK:
        begin
          havePrevFf <= 1'b1;
          prevToggleFf <= dqS3[POS_TOGGLE];
          cntFf <= 3'(ACC_CYC);
          if (havePrevFf && dqS3[POS_TOGGLE] == prevToggleFf)
            state_ff <= ST_IDLE;
          else if (havePrevFf && dqS3[POS_EXCEEDED] && !rbSync[2])
          begin
            opFf <= OP_RESET;
            idxFf <= 3'h0;
            pollFf <= 1'b0;
            state_ff <= ST_WSET;
          end
          else
            state_ff <= ST_RACC;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // flash pin drive; data bus driven only through write cycles
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flAddr <= 23'h000000;
      flDqOut <= 16'h0000;
      flDqOe <= 1'b0;
      flCeN <= 1'b1;
      flOeN <= 1'b1;
      flWeN <= 1'b1;
      flResetN <= 1'b1;
      flAccelHigh <= 1'b0;
    end
    else
    begin
      flResetN <= !hwResetFf;
      flAccelHigh <= accelFf;
      flCeN <= !(state_ff == ST_WSET || state_ff == ST_WLOW || state_ff == ST_RACC
                 || state_ff == ST_RCAP || (state_ff == ST_WHIGH && cntFf != 3'h0));
      flWeN <= state_ff != ST_WLOW;
      flOeN <= !(state_ff == ST_RACC || state_ff == ST_RCAP);
      flDqOe <= state_ff == ST_WSET || state_ff == ST_WLOW;
      flDqOut <= step[15:0];
      flAddr <= (state_ff == ST_WSET || state_ff == ST_WLOW || state_ff == ST_WHIGH)
                ? step[38:16] : addrFf;
    end
  end

endmodule

// [rtl/fcs_pkg.sv]
package fcs_pkg;
  // controller orders written to the command register
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_RESET = 4'h1;
  localparam logic [3:0] OP_AUTOSEL = 4'h2;
  localparam logic [3:0] OP_SEC_ENTER = 4'h3;
  localparam logic [3:0] OP_SEC_EXIT = 4'h4;
  localparam logic [3:0] OP_PROGRAM = 4'h5;
  localparam logic [3:0] OP_BYP_ENTER = 4'h6;
  localparam logic [3:0] OP_BYP_PROG = 4'h7;
  localparam logic [3:0] OP_BYP_EXIT = 4'h8;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h9;
  localparam logic [3:0] OP_SUSPEND = 4'ha;
  localparam logic [3:0] OP_RESUME = 4'hb;
  // flash command addresses and data
  localparam logic [22:0] ADR_UNLOCK1 = 23'h000555;
  localparam logic [22:0] ADR_UNLOCK2 = 23'h0002aa;
  localparam logic [22:0] ADR_ANY = 23'h000000;
  localparam logic [15:0] DAT_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] DAT_UNLOCK2 = 16'h0055;
  localparam logic [15:0] DAT_RESET = 16'h00f0;
  localparam logic [15:0] DAT_AUTOSEL = 16'h0090;
  localparam logic [15:0] DAT_SECURED = 16'h0088;
  localparam logic [15:0] DAT_PROG = 16'h00a0;
  localparam logic [15:0] DAT_BYPASS = 16'h0020;
  localparam logic [15:0] DAT_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] DAT_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] DAT_SUSPEND = 16'h00b0;
  localparam logic [15:0] DAT_RESUME = 16'h0030;
  localparam logic [15:0] DAT_ZERO = 16'h0000;
  // status bit positions in flash read data
  localparam int POS_TOGGLE = 6;
  localparam int POS_EXCEEDED = 5;
  // register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_PINCTRL = 8'h14;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_EXCEEDED = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_AUTOSEL = 3;
  localparam int ST_SECURED = 4;
  localparam int ST_BYPASS = 5;
  localparam int ST_SUSPEND = 6;
  localparam int ST_READY = 7;
  // pin control fields
  localparam int PC_ACCEL = 0;
  localparam int PC_HWRESET = 1;
  // timing in ns and derived cycle counts
  localparam int CLK_NS = 40;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 30;
  localparam int T_ACC_NS = 90;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  // sequencer states, gray along write then poll path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WSET = 3'b001,
    ST_WLOW = 3'b011,
    ST_WHIGH = 3'b010,
    ST_RACC = 3'b110,
    ST_RCAP = 3'b111,
    ST_PCHK = 3'b101
  } fcs_state_e;
endpackage

// [bench/fcs_flash_host_sva.sv]
`timescale 1ns/1ps
module fcs_flash_host_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // flash pins
  input wire logic [22:0] flAddr,
  input wire logic [15:0] flDqOut,
  input wire logic [15:0] flDqIn,
  input wire logic flDqOe,
  input wire logic flCeN,
  input wire logic flOeN,
  input wire logic flWeN,
  input wire logic flResetN,
  input wire logic flAccelHigh,
  input wire logic flReadyBusy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // apb answers at once, places above 8'h14 refused
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("apb access without ready");
  a_apb_error: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  // write strobe shape on the flash bus
  a_we_in_ce: assert property (!flWeN |-> !flCeN && flOeN && flDqOe)
    else $error("write strobe outside a driven selected cycle");
  a_we_setup: assert property ($fell(flWeN) |-> !$past(flCeN) && $stable(flAddr))
    else $error("write strobe without setup cycle");
  a_we_pulse: assert property (
    $fell(flWeN) |=> $rose(flWeN) && $stable(flAddr) && $stable(flDqOut))
    else $error("write strobe not one cycle with held address and data");
  a_ce_release: assert property ($rose(flWeN) |-> !flCeN ##1 flCeN)
    else $error("chip select not held one cycle after strobe");
  // unlock cycles carry their fixed pairs
  a_unlock_one: assert property (
    !flWeN && flDqOut == 16'h00aa |-> flAddr == 23'h000555)
    else $error("first unlock at wrong address");
  a_unlock_two: assert property (
    !flWeN && flDqOut == 16'h0055 |-> flAddr == 23'h0002aa)
    else $error("second unlock at wrong address");
  // reads never clash with the controller's own drive
  a_no_clash: assert property (!flOeN |-> !flDqOe && !flCeN && flWeN)
    else $error("output enable while driving");
  a_read_hold: assert property ($fell(flOeN) |-> !flOeN [*3])
    else $error("read shorter than three cycles");
endmodule

// [bench/fcs_flash_model.sv]
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h00c3, // arbitrary value
  parameter logic [15:0] PART_ID = 16'h5a11 // arbitrary value
) (
  // strobes
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  // mode pins
  input wire logic resetN,
  input wire logic accelHigh,
  // address, data and ready/busy
  input wire logic [22:0] addr,
  input wire logic [15:0] dqIn,
  output logic [15:0] dqOut,
  output logic readyBusy
);
  logic [15:0] mem_ff [16];
  logic [15:0] last_ff, rdVal;
  logic [22:0] adr_ff;
  logic [2:0] step_ff;
  // mode: 0 read, 1 autoselect, 2 secured, 3 bypass
  logic [1:0] mode_ff;
  logic busy_ff, tog_ff;
  time doneAt;
  // powers up reading an erased array
  initial
  begin
    mode_ff = 2'h0;
    step_ff = 3'h0;
    busy_ff = 1'b0;
    tog_ff = 1'b0;
    last_ff = 16'h0;
    foreach (mem_ff[i]) mem_ff[i] = 16'hffff;
  end
  // status while busy, else mode data
  assign rdVal = busy_ff ? {9'h0, tog_ff, 6'h0} : mode_ff == 2'h1 ?
    (addr[7:0] == 8'h0 ? MAKER_ID : addr[7:0] == 8'h1 ? PART_ID : 16'h0) :
    mode_ff == 2'h2 ? {13'h1ca0, addr[2:0]} : mem_ff[addr[3:0]];
  // released bus shows the inverse of the last word
  assign dqOut = (!ceN && !oeN) ? rdVal : ~last_ff;
  assign readyBusy = !busy_ff;
  always @(negedge oeN) tog_ff = ~tog_ff;
  always @(posedge oeN) last_ff = rdVal;
  // embedded work ends back in read
  always #40
    if (busy_ff && $time >= doneAt)
      busy_ff = 1'b0;
  // hardware reset stops work at once
  always @(negedge resetN)
  begin
    busy_ff = 1'b0;
    mode_ff = 2'h0;
    step_ff = 3'h0;
  end
  always @(posedge accelHigh) mode_ff = 2'h3;
  // address at the write strobe fall, chip select already low
  always @(negedge weN)
    if (!ceN)
      adr_ff = addr;
  always @(posedge weN)
    if (!ceN && !busy_ff)
      cmd(adr_ff[10:0], dqIn);
  task automatic cmd(input logic [10:0] a, input logic [15:0] d);
    logic [2:0] s;
    s = step_ff;
    step_ff = 3'h0;
    // last program cycle only clears bits
    if (s == 3'h6)
    begin
      mem_ff[a[3:0]] = mem_ff[a[3:0]] & d;
      busy_ff = 1'b1;
      doneAt = $time + 2000;
    end
    // reset ignores address and leaves autoselect
    else if (d == 16'hf0 && mode_ff != 2'h3)
      mode_ff = 2'h0;
    else if (s == 3'h7)
      mode_ff = d == 16'h0 ? 2'h0 : mode_ff;
    // bypass takes only program and exit
    else if (mode_ff == 2'h3)
      step_ff = d == 16'ha0 ? 3'h6 : d == 16'h90 ? 3'h7 : 3'h0;
    // unlock pairs checked; others drop to idle
    else if (s == 3'h0 || s == 3'h3)
      step_ff = a == 11'h555 && d == 16'haa ? s + 3'h1 : 3'h0;
    else if (s == 3'h1 || s == 3'h4)
      step_ff = a == 11'h2aa && d == 16'h55 ? s + 3'h1 : 3'h0;
    // sixth write erases the whole array
    else if (s == 3'h5 && a == 11'h555 && d == 16'h10)
    begin
      foreach (mem_ff[i]) mem_ff[i] = 16'hffff;
      busy_ff = 1'b1;
      doneAt = $time + 4000;
    end
    else if (s == 3'h2 && a == 11'h555)
      case (d)
        16'h90: step_ff = mode_ff == 2'h2 ? 3'h7 : 3'h0;
        16'h88: mode_ff = 2'h2;
        16'ha0: step_ff = 3'h6;
        16'h20: mode_ff = 2'h3;
        16'h80: step_ff = 3'h3;
        default: step_ff = 3'h0;
      endcase
    if (s == 3'h2 && a == 11'h555 && d == 16'h90 && mode_ff != 2'h2)
      mode_ff = 2'h1;
  endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import fcs_pkg::*;
  localparam logic [15:0] MAKER = 16'h00c3; // arbitrary value
  localparam logic [15:0] PART = 16'h5a11; // arbitrary value
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [22:0] flAddr;
  logic [15:0] flDqOut, flDqIn, memDq;
  logic flDqOe, flCeN, flOeN, flWeN, flResetN, flAccelHigh, flReadyBusy;
  int badCount, nTests, cyc;
  // shared data wire: controller drive wins when enabled
  assign flDqIn = flDqOe ? flDqOut : memDq;
  fcs_flash_host fcs_flash_host_i (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .flAddr, .flDqOut, .flDqIn, .flDqOe, .flCeN,
    .flOeN, .flWeN, .flResetN, .flAccelHigh, .flReadyBusy);
  fcs_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) fcs_flash_model_i (.ceN(flCeN),
    .oeN(flOeN), .weN(flWeN), .resetN(flResetN), .accelHigh(flAccelHigh), .addr(flAddr),
    .dqIn(flDqOut), .dqOut(memDq), .readyBusy(flReadyBusy));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [3:0] c);
    apb(1'b1, REG_CMD, {28'h0, c});
    do apb(1'b0, REG_STATUS, 32'h0); while (q[ST_BUSY] !== 1'b0);
  endtask
  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    apb(1'b1, REG_ADDR, {9'h0, a});
    apb(1'b1, REG_WDATA, {16'h0, d});
  endtask
  task automatic rdf(input logic [22:0] a, input logic [15:0] e, input string n);
    apb(1'b1, REG_ADDR, {9'h0, a});
    op(OP_READ);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(n, q, {16'h0, e});
  endtask
  task automatic t_reset_read;
    // let the ready pin pass its synchroniser first
    repeat (4) @(posedge sys_clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", q, 32'h80);
    rdf(23'h3, 16'hffff, "array");
  endtask
  task automatic t_autosel;
    op(OP_AUTOSEL);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("autosel", q[ST_AUTOSEL], 1'b1);
    rdf(23'h7f00, MAKER, "maker");
    rdf(23'h0101, PART, "part");
    rdf(23'h1402, 16'h0, "protect");
    rdf(23'h0101, PART, "part again");
    op(OP_RESET);
    rdf(23'h0101, 16'hffff, "after reset");
  endtask
  task automatic t_program;
    wr(23'h5, 16'h0ff0);
    op(OP_PROGRAM);
    rdf(23'h5, 16'h0ff0, "program");
    wr(23'h5, 16'hf0ff);
    op(OP_PROGRAM);
    rdf(23'h5, 16'h00f0, "no set");
    apb(1'b0, REG_STATUS, 32'h0);
    chk("ready", q[7:0], 8'h80);
  endtask
  task automatic t_bypass;
    op(OP_BYP_ENTER);
    wr(23'h8, 16'h1234);
    op(OP_BYP_PROG);
    wr(23'h9, 16'h4321);
    op(OP_BYP_PROG);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("bypass", q[ST_BYPASS], 1'b1);
    op(OP_BYP_EXIT);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("bypass off", q[ST_BYPASS], 1'b0);
    rdf(23'h8, 16'h1234, "byp word");
    rdf(23'h9, 16'h4321, "byp word2");
  endtask
  task automatic t_secured;
    op(OP_SEC_ENTER);
    rdf(23'h2, 16'he502, "serial");
    op(OP_SEC_EXIT);
    rdf(23'h2, 16'hffff, "array back");
  endtask
  task automatic t_erase;
    op(OP_CHIP_ERASE);
    rdf(23'h5, 16'hffff, "erased");
  endtask
  task automatic t_refuse;
    apb(1'b1, REG_CMD, {28'h0, OP_BYP_PROG});
    apb(1'b0, REG_STATUS, 32'h0);
    chk("refused", q[ST_REFUSED], 1'b1);
    apb(1'b1, REG_STATUS, 32'h4);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("cleared", q[ST_REFUSED], 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", perr, 1'b1);
  endtask
  task automatic t_accel;
    apb(1'b1, REG_PINCTRL, 32'h1);
    wr(23'ha, 16'h5a5a);
    op(OP_BYP_PROG);
    apb(1'b1, REG_PINCTRL, 32'h0);
    rdf(23'ha, 16'h5a5a, "accel");
  endtask
  task automatic t_hwreset;
    op(OP_AUTOSEL);
    apb(1'b1, REG_PINCTRL, 32'h2);
    apb(1'b1, REG_PINCTRL, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("hw reset mode", q[ST_AUTOSEL], 1'b0);
    rdf(23'h3, 16'hffff, "hw reset read");
  endtask
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset_read;
    t_autosel;
    t_program;
    t_bypass;
    t_secured;
    t_erase;
    t_refuse;
    t_accel;
    t_hwreset;
    reportAndStop;
  end
  // watchdog on the whole run
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      badCount++;
      reportAndStop;
    end
  end
endmodule
bind fcs_flash_host fcs_flash_host_sva fcs_flash_host_sva_i (.sys_clk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flAddr, .flDqOut,
  .flDqIn, .flDqOe, .flCeN, .flOeN, .flWeN, .flResetN, .flAccelHigh, .flReadyBusy);
